// >>> imsfw_top.v
// interface mode selection with send-immediate / wake-up input handling
// assumes cfg_valid pulses once per reset with the configuration word, and
// flush_wake_n / modem_call_indicator_n arrive asynchronously from pins
// data_held comes from logic on ref_clk
`timescale 1ns/1ps
`include "imsfw_regs.vh"

module imsfw_top #(
    parameter WAKE_CYC = `IMSFW_WAKE_CYC
) (
    input  wire        ref_clk,
    input  wire        resetn,

    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,

    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,

    input  wire [7:0]  cfg_word,
    input  wire        cfg_valid,
    input  wire        flush_wake_n,
    input  wire        modem_call_indicator_n,
    input  wire        data_held,

    output reg         short_packet_req,
    output reg         remote_wake_req,
    output reg  [3:0]  op_mode,
    output reg  [1:0]  io_drive_sel,
    output reg         io_slow_slew,
    output reg         io_schmitt_en,
    output reg         fast_serial_rst
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // flush length kept for reference only: a flush acts on the edge
    localparam [31:0] FLUSH_CYC = `IMSFW_FLUSH_CYC;
    localparam [31:0] WAKE_LEN  = WAKE_CYC;
    localparam [31:0] CTRL_RST  = `IMSFW_CTRL_RESET;

    // registers and mode state
    reg  [31:0] ctrl_reg;
    reg  [7:0]  cfg_reg;
    reg         loaded_reg;
    reg  [2:0]  base_reg;
    reg  [3:0]  op_next;

    // pin synchronisers and edge history
    reg  [1:0]  fw_sync_reg;
    reg  [1:0]  ri_sync_reg;
    reg         fw_prev_reg;
    reg         ri_prev_reg;

    // low-time count and event flags
    reg  [31:0] low_cnt_reg;
    reg         wake_done_reg;
    reg         flush_sticky_reg;
    reg         wake_sticky_reg;
    reg  [31:0] flush_count_reg;

    // write halves held until both are in
    reg         aw_held_reg;
    reg         w_held_reg;
    reg  [31:0] awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;

    // levels and edges seen after the second flop
    wire fw_level    = fw_sync_reg[1];
    wire ri_level    = ri_sync_reg[1];
    wire fw_fall     = fw_prev_reg & ~fw_level;
    wire ri_fall     = ri_prev_reg & ~ri_level;

    wire pd_en       = ctrl_reg[`IMSFW_CTRL_PD_BIT];
    wire suspended   = ctrl_reg[`IMSFW_CTRL_SUSP_BIT];

    // fifo modes and both bit-bang modes accept the input
    wire fw_allowed  = (op_mode == `IMSFW_OP_AFIFO) | (op_mode == `IMSFW_OP_CPUFIFO) |
                       (op_mode == `IMSFW_OP_SFIFO) | (op_mode == `IMSFW_OP_ABB) |
                       (op_mode == `IMSFW_OP_SBB);
    wire wake_hit    = fw_allowed & ~fw_level & ~wake_done_reg &
                       (low_cnt_reg == WAKE_LEN - 32'h00000001);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // history resets to the idle high level, so no false edge follows reset
    always @(posedge ref_clk) begin
        if (!resetn) begin
            fw_sync_reg <= 2'h3;
            ri_sync_reg <= 2'h3;
            fw_prev_reg <= 1'b1;
            ri_prev_reg <= 1'b1;
        end else begin
            fw_sync_reg <= {fw_sync_reg[0], flush_wake_n};
            ri_sync_reg <= {ri_sync_reg[0], modem_call_indicator_n};
            fw_prev_reg <= fw_level;
            ri_prev_reg <= ri_level;
        end
    end

    // ----------------------------------------------------------------
    // configuration load and mode selection
    // ----------------------------------------------------------------
    // host command only acts after enumeration; fast serial cannot be left or
    // entered from the host, only its controller reset
    always @* begin
        op_next = op_mode;
        if (ctrl_reg[`IMSFW_CTRL_GO_BIT] && ctrl_reg[`IMSFW_CTRL_ENUM_BIT] &&
            base_reg != `IMSFW_BASE_FSER) begin
            // codes outside the table leave the mode alone
            case (ctrl_reg[`IMSFW_CTRL_CMD_MSB:`IMSFW_CTRL_CMD_LSB])
                `IMSFW_CMD_RESET:  op_next = {1'b0, base_reg};
                `IMSFW_CMD_ABB:    op_next = `IMSFW_OP_ABB;
                `IMSFW_CMD_SBB:    op_next = `IMSFW_OP_SBB;
                `IMSFW_CMD_SERENG: op_next = `IMSFW_OP_SERENG;
                `IMSFW_CMD_SFIFO: begin
                    if (base_reg == `IMSFW_BASE_AFIFO)
                        op_next = `IMSFW_OP_SFIFO;
                end
                default:           op_next = op_mode;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            base_reg      <= `IMSFW_BASE_UART;
            op_mode       <= `IMSFW_OP_UART;
            loaded_reg    <= 1'b0;
            cfg_reg       <= 8'h00;
            io_drive_sel  <= 2'h0;
            io_slow_slew  <= 1'b0;
            io_schmitt_en <= 1'b0;
        end else if (cfg_valid && !loaded_reg) begin
            loaded_reg    <= 1'b1;
            cfg_reg       <= cfg_word;
            // unknown base codes keep uart
            if (cfg_word[`IMSFW_CFG_MODE_MSB:`IMSFW_CFG_MODE_LSB] <= `IMSFW_BASE_FSER) begin
                base_reg <= cfg_word[`IMSFW_CFG_MODE_MSB:`IMSFW_CFG_MODE_LSB];
                op_mode  <= {1'b0, cfg_word[`IMSFW_CFG_MODE_MSB:`IMSFW_CFG_MODE_LSB]};
            end
            io_drive_sel  <= cfg_word[`IMSFW_CFG_DRV_MSB:`IMSFW_CFG_DRV_LSB];
            io_slow_slew  <= cfg_word[`IMSFW_CFG_SLEW_BIT];
            io_schmitt_en <= cfg_word[`IMSFW_CFG_SCHM_BIT];
        end else if (loaded_reg) begin
            op_mode <= op_next;
        end
    end

    // ----------------------------------------------------------------
    // flush / wake detection
    // ----------------------------------------------------------------
    // flush fires on the falling edge itself, so a wake pulse with data_held set also flushes first
    always @(posedge ref_clk) begin
        if (!resetn) begin
            low_cnt_reg      <= 32'h00000000;
            wake_done_reg    <= 1'b0;
            short_packet_req <= 1'b0;
            remote_wake_req  <= 1'b0;
            flush_count_reg  <= 32'h00000000;
        end else begin
            short_packet_req <= 1'b0;
            remote_wake_req  <= 1'b0;

            // the count freezes once a wake is seen: one wake per low period
            if (fw_level) begin
                low_cnt_reg   <= 32'h00000000;
                wake_done_reg <= 1'b0;
            end else if (!wake_done_reg) begin
                low_cnt_reg <= low_cnt_reg + 32'h00000001;
            end

            if (fw_allowed && fw_fall && data_held) begin
                short_packet_req <= 1'b1;
                flush_count_reg  <= flush_count_reg + 32'h00000001;
            end

            if (wake_hit) begin
                wake_done_reg <= 1'b1;
                if (suspended && !pd_en)
                    remote_wake_req <= 1'b1;
            end

            if (op_mode == `IMSFW_OP_UART && ri_fall && suspended)
                remote_wake_req <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    // a channel is refused while its word is held or a response waits
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // a held word is used ahead of the live bus
    wire        aw_ok   = aw_held_reg | s_axi_awvalid;
    wire        w_ok    = w_held_reg | s_axi_wvalid;
    wire [31:0] wa      = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wd      = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]  ws      = w_held_reg ? wstrb_reg : s_axi_wstrb;

    wire        do_wr   = aw_ok & w_ok & ~s_axi_bvalid;
    wire        wr_ctrl = wa[7:0] == `IMSFW_OFF_CTRL;
    wire        wr_stat = wa[7:0] == `IMSFW_OFF_STATUS;
    wire        wr_hit  = (wa[31:8] == 24'h000000) & (wr_ctrl | wr_stat);

    // write-one-to-clear on the status flags; a new event wins over the clear
    wire clr_flush = do_wr & wr_hit & wr_stat & ws[0] & wd[`IMSFW_ST_FLUSH_BIT];
    wire clr_wake  = do_wr & wr_hit & wr_stat & ws[0] & wd[`IMSFW_ST_WAKE_BIT];

    // pin low, wake, flush, loaded, mode
    wire [31:0] status_word = {24'h000000, ~fw_level, wake_sticky_reg, flush_sticky_reg,
                               loaded_reg, op_mode};

    // control register, one process per byte lane
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            always @(posedge ref_clk) begin
                if (!resetn)
                    ctrl_reg[gi*8 +: 8] <= CTRL_RST[gi*8 +: 8];
                else if (do_wr && wr_hit && wr_ctrl && ws[gi])
                    ctrl_reg[gi*8 +: 8] <= wd[gi*8 +: 8];
                else if (gi == 1)
                    ctrl_reg[gi*8 +: 1] <= 1'b0; // go bit self-clears after one cycle
            end
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (!resetn) begin
            aw_held_reg      <= 1'b0;
            w_held_reg       <= 1'b0;
            awaddr_reg       <= 32'h00000000;
            wdata_reg        <= 32'h00000000;
            wstrb_reg        <= 4'h0;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= 2'h0;
            s_axi_rvalid     <= 1'b0;
            s_axi_rresp      <= 2'h0;
            s_axi_rdata      <= 32'h00000000;
            flush_sticky_reg <= 1'b0;
            wake_sticky_reg  <= 1'b0;
            fast_serial_rst  <= 1'b0;
        end else begin
            // aw and w come in either order; each waits for the other
            if (do_wr) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_reg <= 1'b1;
                    wdata_reg  <= s_axi_wdata;
                    wstrb_reg  <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end

            // one-cycle controller reset, only meaningful in fast serial mode
            fast_serial_rst <= do_wr & wr_hit & wr_ctrl & ws[1] &
                               wd[`IMSFW_CTRL_FSRST_BIT] &
                               (op_mode == `IMSFW_OP_FSER);

            if (short_packet_req)
                flush_sticky_reg <= 1'b1;
            else if (clr_flush)
                flush_sticky_reg <= 1'b0;

            if (remote_wake_req)
                wake_sticky_reg <= 1'b1;
            else if (clr_wake)
                wake_sticky_reg <= 1'b0;

            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                if (s_axi_araddr[31:8] != 24'h000000) begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end else begin
                    // offsets outside the map answer with slverr
                    case (s_axi_araddr[7:0])
                        `IMSFW_OFF_CTRL:   s_axi_rdata <= ctrl_reg;
                        `IMSFW_OFF_CFG:    s_axi_rdata <= {24'h000000, cfg_reg};
                        `IMSFW_OFF_STATUS: s_axi_rdata <= status_word;
                        `IMSFW_OFF_COUNT:  s_axi_rdata <= flush_count_reg;
                        default: begin
                            s_axi_rdata <= 32'h00000000;
                            s_axi_rresp <= 2'h2;
                        end
                    endcase
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// >>> imsfw_regs.vh
// register map, field layout, reset values and timing counts of the mode/flush-wake block
// assumes a 100 MHz ref_clk and a 32-bit AXI4-Lite register bus
`ifndef IMSFW_REGS_VH
`define IMSFW_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define IMSFW_OFF_CTRL        8'h00
`define IMSFW_OFF_CFG         8'h04
`define IMSFW_OFF_STATUS      8'h08
`define IMSFW_OFF_COUNT       8'h0C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define IMSFW_CTRL_CMD_LSB    0
`define IMSFW_CTRL_CMD_MSB    7
`define IMSFW_CTRL_GO_BIT     8
`define IMSFW_CTRL_ENUM_BIT   9
`define IMSFW_CTRL_FSRST_BIT  10
`define IMSFW_CTRL_PD_BIT     11
`define IMSFW_CTRL_SUSP_BIT   12
`define IMSFW_CTRL_RESET      32'h00000000

// ----------------------------------------------------------------
// configuration memory word layout
// ----------------------------------------------------------------
`define IMSFW_CFG_MODE_LSB    0
`define IMSFW_CFG_MODE_MSB    2
`define IMSFW_CFG_DRV_LSB     4
`define IMSFW_CFG_DRV_MSB     5
`define IMSFW_CFG_SLEW_BIT    6
`define IMSFW_CFG_SCHM_BIT    7

// ----------------------------------------------------------------
// base mode codes held in configuration memory
// ----------------------------------------------------------------
`define IMSFW_BASE_UART       3'h0
`define IMSFW_BASE_AFIFO      3'h1
`define IMSFW_BASE_CPUFIFO    3'h2
`define IMSFW_BASE_HDSER      3'h3
`define IMSFW_BASE_FSER       3'h4

// ----------------------------------------------------------------
// host bit-mode command values
// ----------------------------------------------------------------
`define IMSFW_CMD_RESET       8'h00
`define IMSFW_CMD_ABB         8'h01
`define IMSFW_CMD_SERENG      8'h02
`define IMSFW_CMD_SBB         8'h04
`define IMSFW_CMD_SFIFO       8'h40

// ----------------------------------------------------------------
// operating mode codes reported in status
// ----------------------------------------------------------------
`define IMSFW_OP_UART         4'h0
`define IMSFW_OP_AFIFO        4'h1
`define IMSFW_OP_CPUFIFO      4'h2
`define IMSFW_OP_HDSER        4'h3
`define IMSFW_OP_FSER         4'h4
`define IMSFW_OP_ABB          4'h5
`define IMSFW_OP_SBB          4'h6
`define IMSFW_OP_SERENG       4'h7
`define IMSFW_OP_SFIFO        4'h8

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define IMSFW_ST_MODE_LSB     0
`define IMSFW_ST_MODE_MSB     3
`define IMSFW_ST_LOADED_BIT   4
`define IMSFW_ST_FLUSH_BIT    5
`define IMSFW_ST_WAKE_BIT     6
`define IMSFW_ST_LOW_BIT      7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IMSFW_CLK_HZ          100000000
`define IMSFW_WAKE_MS         20
`define IMSFW_WAKE_CYC        (`IMSFW_CLK_HZ / 1000 * `IMSFW_WAKE_MS)
`define IMSFW_FLUSH_NS        250
`define IMSFW_FLUSH_CYC       ((`IMSFW_FLUSH_NS * 100 + 999) / 1000)

`endif

// >>> imsfw_peer.sv
// peripheral logic and configuration memory facing the mode/flush-wake block
// assumes the bench calls these tasks; every pin changes by nba just after a rising edge
`timescale 1ns/1ps
module imsfw_peer (
    input  wire       ref_clk,
    output reg  [7:0] cfg_word,
    output reg        cfg_valid,
    output reg        flush_wake_n,
    output reg        modem_call_indicator_n,
    output reg        data_held
);
    // both pins idle high, as their pull-ups leave them
    initial {cfg_word, cfg_valid, flush_wake_n, modem_call_indicator_n, data_held} = 12'h006;

    // one word per reset; the bus shows the inverse once released
    task load(input [7:0] w);
        begin
            @(posedge ref_clk);
            cfg_word  <= w;
            cfg_valid <= 1'b1;
            @(posedge ref_clk);
            cfg_valid <= 1'b0;
            cfg_word  <= ~w;
        end
    endtask

    // 25 cycles is a flush pulse, a scaled wake length a wake pulse
    task pin_low(input integer n);
        begin
            @(posedge ref_clk);
            flush_wake_n <= 1'b0;
            repeat (n) @(posedge ref_clk);
            flush_wake_n <= 1'b1;
        end
    endtask

    // writing stops before any flush: data_held never moves inside pin_low
    task hold(input v);
        begin
            @(posedge ref_clk);
            data_held <= v;
        end
    endtask

    task ring;
        begin
            @(posedge ref_clk);
            modem_call_indicator_n <= 1'b0;
            repeat (10) @(posedge ref_clk);
            modem_call_indicator_n <= 1'b1;
        end
    endtask
endmodule

// >>> imsfw_top_sva.sv
// port-level checks of mode selection and flush/wake pulses
// assumes cfg_valid carries the configuration word once per reset
`timescale 1ns/1ps
`include "imsfw_regs.vh"
module imsfw_sva #(
    parameter WAKE_CYC = 50
) (
    input wire       ref_clk,
    input wire       resetn,
    input wire [7:0] cfg_word,
    input wire       cfg_valid,
    input wire       flush_wake_n,
    input wire       modem_call_indicator_n,
    input wire       data_held,
    input wire       short_packet_req,
    input wire       remote_wake_req,
    input wire [3:0] op_mode,
    input wire [1:0] io_drive_sel,
    input wire       io_slow_slew,
    input wire       io_schmitt_en,
    input wire       fast_serial_rst
);
    reg  [7:0]  cfg_q;
    reg         loaded;
    reg  [2:0]  age;
    reg  [31:0] low_cnt;
    wire        fifo_bb = (op_mode == `IMSFW_OP_AFIFO) || (op_mode == `IMSFW_OP_CPUFIFO) ||
                          (op_mode == `IMSFW_OP_ABB) || (op_mode == `IMSFW_OP_SBB) ||
                          (op_mode == `IMSFW_OP_SFIFO);

    always @(posedge ref_clk) begin
        if (!resetn) begin
            loaded  <= 1'b0;
            cfg_q   <= 8'h00;
            age     <= 3'h0;
            low_cnt <= 32'h0;
        end else begin
            if (cfg_valid && !loaded) begin
                loaded <= 1'b1;
                cfg_q  <= cfg_word;
            end
            if (loaded && age != 3'h7)
                age <= age + 3'h1;
            low_cnt <= flush_wake_n ? 32'h0 : low_cnt + 32'h1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_flush_mode: assert property (short_packet_req |-> fifo_bb)
        else $error("flush pulse outside fifo or bit-bang mode");
    a_flush_pulse: assert property (short_packet_req |=> !short_packet_req)
        else $error("short packet request longer than one cycle");
    a_flush_fall: assert property (short_packet_req |-> !$past(flush_wake_n, 2))
        else $error("flush pulse without a low pin");
    a_wake_long: assert property (remote_wake_req && op_mode != `IMSFW_OP_UART
        |-> fifo_bb && low_cnt >= WAKE_CYC)
        else $error("wake before the low time ran out");
    a_uart_wake: assert property (remote_wake_req && op_mode == `IMSFW_OP_UART
        |-> !$past(modem_call_indicator_n, 2))
        else $error("uart wake without call indicator");
    a_default_uart: assert property (!loaded |-> op_mode == `IMSFW_OP_UART)
        else $error("mode not uart before configuration");
    a_sync_base: assert property (op_mode == `IMSFW_OP_SFIFO |-> cfg_q[2:0] == 3'h1)
        else $error("sync fifo without async fifo base");
    a_host_mode: assert property (op_mode inside {`IMSFW_OP_ABB, `IMSFW_OP_SBB, `IMSFW_OP_SERENG}
        |-> loaded && cfg_q[2:0] != 3'h4)
        else $error("host mode in fast serial or unloaded");
    a_fs_reset: assert property (fast_serial_rst |-> op_mode == `IMSFW_OP_FSER)
        else $error("fast serial reset in another mode");
    a_io_cfg: assert property (age == 3'h7 |-> {io_schmitt_en, io_slow_slew, io_drive_sel}
        == {cfg_q[7], cfg_q[6], cfg_q[5:4]})
        else $error("io settings differ from configuration");

    c_flush: cover property (short_packet_req);
    c_wake: cover property (remote_wake_req);
    c_sfifo: cover property (op_mode == `IMSFW_OP_SFIFO);
    c_fsrst: cover property (fast_serial_rst);
endmodule

bind imsfw_top imsfw_sva #(.WAKE_CYC(WAKE_CYC)) chk_u (.ref_clk, .resetn, .cfg_word, .cfg_valid,
    .flush_wake_n, .modem_call_indicator_n, .data_held, .short_packet_req, .remote_wake_req,
    .op_mode, .io_drive_sel, .io_slow_slew, .io_schmitt_en, .fast_serial_rst);

// >>> imsfw_top_tb.sv
// self-checking bench: axi4-lite master tasks plus the peripheral model
// assumes a synchronous active-low reset and a 100 MHz ref_clk
`timescale 1ns/1ps
`include "imsfw_regs.vh"
`define CHK(nm, e, g) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
    fail_count = fail_count + 1; $display("BAD %s exp %h got %h", nm, e, g); end end
module imsfw_top_tb;
    localparam WAKE = 50;
    reg         ref_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready;
    reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
    reg  [3:0]  s_axi_wstrb;
    reg  [1:0]  r, b;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp, io_drive_sel;
    wire [31:0] s_axi_rdata;
    wire [7:0]  cfg_word;
    wire [3:0]  op_mode;
    wire        cfg_valid, flush_wake_n, modem_call_indicator_n, data_held, short_packet_req;
    wire        remote_wake_req, io_slow_slew, io_schmitt_en, fast_serial_rst;
    integer     fail_count, n_compared, n_sp, n_wk, n_fs, i;

    imsfw_top #(.WAKE_CYC(WAKE)) dut_u (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_word, .cfg_valid,
        .flush_wake_n, .modem_call_indicator_n, .data_held, .short_packet_req,
        .remote_wake_req, .op_mode, .io_drive_sel, .io_slow_slew, .io_schmitt_en,
        .fast_serial_rst);
    imsfw_peer peer_u (.ref_clk, .cfg_word, .cfg_valid, .flush_wake_n, .modem_call_indicator_n,
        .data_held);

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    // handshakes are sampled at the rising edge; a channel drops valid once taken
    task axi_wr(input [31:0] a, input [31:0] v, input [3:0] s);
        reg hb;
        begin
            @(posedge ref_clk);
            s_axi_awaddr  <= a;
            s_axi_wdata   <= v;
            s_axi_wstrb   <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
            hb = 1'b0;
            while (!hb) begin
                @(posedge ref_clk);
                hb = s_axi_bvalid;
                b  = s_axi_bresp;
                s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
                s_axi_wvalid  <= s_axi_wvalid & ~s_axi_wready;
            end
            s_axi_bready <= 1'b0;
        end
    endtask

    task axi_rd(input [31:0] a);
        reg hr;
        begin
            @(posedge ref_clk);
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
            hr = 1'b0;
            while (!hr) begin
                @(posedge ref_clk);
                hr = s_axi_rvalid;
                d  = s_axi_rdata;
                r  = s_axi_rresp;
                s_axi_arvalid <= s_axi_arvalid & ~s_axi_arready;
            end
            s_axi_rready <= 1'b0;
        end
    endtask

    task idle(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask

    task do_reset(input [7:0] cfg);
        begin
            @(posedge ref_clk);
            resetn <= 1'b0;
            repeat (5) @(posedge ref_clk);
            resetn <= 1'b1;
            idle(1);
            `CHK("mode_pre", `IMSFW_OP_UART, op_mode)
            axi_rd(`IMSFW_OFF_CTRL);
            `CHK("ctrl_rst", `IMSFW_CTRL_RESET, d)
            peer_u.load(cfg);
            idle(4);
        end
    endtask

    task end_of_test;
        begin
            if (fail_count == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // ----------------------------------------------------------------
    // clock, pulse counters, watchdog, sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        if (short_packet_req === 1'b1) n_sp = n_sp + 1;
        if (remote_wake_req === 1'b1) n_wk = n_wk + 1;
        if (fast_serial_rst === 1'b1) n_fs = n_fs + 1;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count = fail_count + 1;
        end_of_test;
    end

    initial begin
        {fail_count, n_compared, n_sp, n_wk, n_fs} = 0;
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
        s_axi_wstrb = 4'hF;
        // async fifo base, 2-step drive, fast slew, schmitt on
        do_reset(8'hA1);
        `CHK("base", `IMSFW_OP_AFIFO, op_mode)
        `CHK("io", 4'hA, {io_schmitt_en, io_slow_slew, io_drive_sel})
        axi_rd(`IMSFW_OFF_CFG);
        `CHK("cfg_reg", 32'h000000A1, d)
        peer_u.hold(1'b1);
        peer_u.pin_low(25);
        idle(4);
        `CHK("flush", 1, n_sp)
        axi_rd(`IMSFW_OFF_COUNT);
        `CHK("count", 32'h00000001, d)
        axi_rd(`IMSFW_OFF_STATUS);
        `CHK("status", 32'h00000031, d)
        peer_u.hold(1'b0);
        peer_u.pin_low(25);
        idle(4);
        `CHK("no_data", 1, n_sp)
        axi_wr(`IMSFW_OFF_CTRL, 32'h00001000, 4'hF);
        peer_u.pin_low(25);
        idle(4);
        `CHK("short_wake", 0, n_wk)
        peer_u.pin_low(WAKE + 10);
        idle(4);
        `CHK("wake", 1, n_wk)
        axi_wr(`IMSFW_OFF_CTRL, 32'h00001800, 4'hF);
        peer_u.pin_low(WAKE + 10);
        idle(4);
        `CHK("pulldown", 1, n_wk)
        for (i = 4; i >= 0; i = i - 1) begin
            axi_wr(`IMSFW_OFF_CTRL, 32'h300 | ({`IMSFW_CMD_RESET, `IMSFW_CMD_SERENG,
                `IMSFW_CMD_SBB, `IMSFW_CMD_ABB, `IMSFW_CMD_SFIFO} >> (8 * i)) & 32'hFF, 4'hF);
            idle(4);
            `CHK("cmd_mode", (20'h17658 >> (4 * i)) & 4'hF, op_mode)
        end
        axi_rd(32'h00000010);
        `CHK("unmapped", 34'h200000000, {r, d})
        axi_wr(32'h00000010, 32'hFFFFFFFF, 4'hF);
        `CHK("wr_unmapped", 2'h2, b)
        axi_wr(`IMSFW_OFF_CTRL, 32'hFFFFFFFF, 4'h1);
        `CHK("wr_ok", 2'h0, b)
        axi_rd(`IMSFW_OFF_CTRL);
        `CHK("ctrl_lane", 32'h000002FF, d)
        do_reset(8'h00);
        peer_u.hold(1'b1);
        peer_u.pin_low(25);
        idle(4);
        `CHK("uart_flush", 1, n_sp)
        axi_wr(`IMSFW_OFF_CTRL, 32'h00000340, 4'hF);
        idle(4);
        `CHK("uart_sfifo", `IMSFW_OP_UART, op_mode)
        axi_wr(`IMSFW_OFF_CTRL, 32'h00001000, 4'hF);
        peer_u.ring;
        peer_u.pin_low(WAKE + 10);
        idle(4);
        `CHK("uart_wake", 2, n_wk)
        do_reset(8'h04);
        `CHK("fser", `IMSFW_OP_FSER, op_mode)
        axi_wr(`IMSFW_OFF_CTRL, 32'h00000301, 4'hF);
        idle(4);
        `CHK("fser_cmd", `IMSFW_OP_FSER, op_mode)
        axi_wr(`IMSFW_OFF_CTRL, 32'h00000400, 4'hF);
        idle(4);
        `CHK("fser_rst", 1, n_fs)
        end_of_test;
    end
endmodule
